// File: hw/sps_pkg.sv
// Shared constants of the byte-wide serial port block.
// Assumes a single 100 MHz clock and a 32-bit AHB-Lite register bus.
package sps_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_DATA  = 8'h08;
    localparam logic [7:0] OFF_CFG   = 8'h0C;
    // ==========================================================
    // Control fields
    localparam int C_IE   = 7;
    localparam int C_EN   = 6;
    localparam int C_LSBF = 5;
    localparam int C_MASTER_ROLE_SELECT = 4;
    localparam int C_CLOCK_IDLE_POLARITY = 3;
    localparam int C_CLOCK_SAMPLE_PHASE = 2;
    // Flag fields
    localparam int F_DONE = 7;
    localparam int F_WRITE_COLLISION_FLAG = 6;
    localparam int F_DBL  = 0;
    // Pin configuration and global interrupt enable fields
    localparam int G_MISO_OUT = 0;
    localparam int G_SS_OUT   = 1;
    localparam int G_SS_VAL   = 2;
    localparam int G_GIE      = 3;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [3:0] RST_CFG  = 4'h4;
    // Edges per byte, minus one
    localparam logic [3:0] LAST_EDGE = 4'hF;
    // HTRANS encoding of a nonsequential transfer
    localparam logic [1:0] TR_NONSEQ = 2'h2;
endpackage

// File: hw/sps_port.sv
// Byte-wide serial port, master or slave, behind an AHB-Lite slave.
// Assumes pins and bus synchronous to hclk; external pad logic
// resolves each pin from its _o and _oe signals.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
module sps_port (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        vector_taken,
    output logic             irq_req,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe,
    input  wire logic        ss_n_i,
    output logic             ss_n_o,
    output logic             ss_n_oe
);
    // ==========================================================
    // Helpers
    // Half SCK period in hclk cycles for {double, rate}
    function automatic logic [6:0] half_cycles(input logic [2:0] code);
        case (code)
            3'h0:    half_cycles = 7'h02;
            3'h1:    half_cycles = 7'h08;
            3'h2:    half_cycles = 7'h20;
            3'h3:    half_cycles = 7'h40;
            3'h4:    half_cycles = 7'h01;
            3'h5:    half_cycles = 7'h04;
            3'h6:    half_cycles = 7'h10;
            default: half_cycles = 7'h20;
        endcase
    endfunction

    // Shift one received bit in, honouring bit order
    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                            input logic lsbf);
        shift_in = lsbf ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    // ==========================================================
    // State
    logic [7:0] ctrl_r;
    logic [3:0] cfg_r;
    logic       dbl_r;
    logic       done_r;
    logic       write_collision_flag_r;
    logic [7:0] rxbuf_r;
    logic [7:0] sh_r;
    logic       in_r;
    logic [3:0] edge_r;
    logic       busy_r;
    logic [6:0] div_r;
    logic       sck_r;
    logic       arm_done_r;
    logic       arm_write_collision_flag_r;
    logic       wr_pend_r;
    logic [7:0] wr_addr_r;
    logic       sck1_r, sck2_r, sck3_r;
    logic       mosi1_r, mosi2_r;
    logic       ss1_r, ss2_r;

    logic       en, master_role_select, clock_sample_phase, lsbf;
    logic       ss_in_mode, demote, slv_sel;
    logic       ev, m_ev, s_ev, din, samp, fin;
    logic       out_bit, in_prog;
    logic       acc, rd_acc, data_acc, data_wr, start;
    logic [7:0] fin_byte;

    assign en   = ctrl_r[sps_pkg::C_EN];
    assign master_role_select = ctrl_r[sps_pkg::C_MASTER_ROLE_SELECT];
    assign clock_sample_phase = ctrl_r[sps_pkg::C_CLOCK_SAMPLE_PHASE];
    assign lsbf = ctrl_r[sps_pkg::C_LSBF];

    // ==========================================================
    // Bus decode
    // Address-phase access and its side effects
    assign acc      = hsel && hready && (htrans == sps_pkg::TR_NONSEQ);
    assign rd_acc   = acc && !hwrite;
    assign data_acc = (acc && !hwrite && haddr == sps_pkg::OFF_DATA) ||
                      (wr_pend_r && wr_addr_r == sps_pkg::OFF_DATA);
    assign data_wr  = wr_pend_r && wr_addr_r == sps_pkg::OFF_DATA;

    // Capture write address phase; data lands next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= acc && hwrite;
            wr_addr_r <= haddr;
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            case (haddr)
                sps_pkg::OFF_CTRL:  hrdata <= {24'h00_0000, ctrl_r};
                sps_pkg::OFF_FLAGS: hrdata <= {24'h00_0000, done_r, write_collision_flag_r,
                                               5'h00, dbl_r};
                sps_pkg::OFF_DATA:  hrdata <= {24'h00_0000, rxbuf_r};
                sps_pkg::OFF_CFG:   hrdata <= {28'h000_0000, cfg_r};
                default:            hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Software registers
    assign ss_in_mode = !cfg_r[sps_pkg::G_SS_OUT];
    assign demote     = en && master_role_select && ss_in_mode && !ss2_r;

    // Control; demotion beats a same-cycle write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= sps_pkg::RST_CTRL;
        end else begin
            if (wr_pend_r && wr_addr_r == sps_pkg::OFF_CTRL)
                ctrl_r <= hwdata[7:0];
            if (demote)
                ctrl_r[sps_pkg::C_MASTER_ROLE_SELECT] <= 1'b0;
        end
    end

    // Pin configuration and double-rate bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= sps_pkg::RST_CFG;
            dbl_r <= 1'b0;
        end else begin
            if (wr_pend_r && wr_addr_r == sps_pkg::OFF_CFG)
                cfg_r <= hwdata[3:0];
            if (wr_pend_r && wr_addr_r == sps_pkg::OFF_FLAGS)
                dbl_r <= hwdata[sps_pkg::F_DBL];
        end
    end

    // Status read arms the clear; data access fires it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_done_r <= 1'b0;
            arm_write_collision_flag_r <= 1'b0;
        end else if (rd_acc && haddr == sps_pkg::OFF_FLAGS) begin
            arm_done_r <= done_r || write_collision_flag_r;
            arm_write_collision_flag_r <= write_collision_flag_r;
        end else if (data_acc) begin
            arm_done_r <= 1'b0;
            arm_write_collision_flag_r <= 1'b0;
        end
    end

    // Done flag; a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r <= 1'b0;
        end else if (fin || demote) begin
            done_r <= 1'b1;
        end else if (vector_taken || (data_acc && arm_done_r)) begin
            done_r <= 1'b0;
        end
    end

    // Collision flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_collision_flag_r <= 1'b0;
        end else if (data_wr && in_prog) begin
            write_collision_flag_r <= 1'b1;
        end else if (data_acc && arm_write_collision_flag_r) begin
            write_collision_flag_r <= 1'b0;
        end
    end

    // Interrupt request level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= done_r && ctrl_r[sps_pkg::C_IE] && cfg_r[sps_pkg::G_GIE];
        end
    end

    // ==========================================================
    // Synchronisers for the slave side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck1_r  <= 1'b0;
            sck2_r  <= 1'b0;
            sck3_r  <= 1'b0;
            mosi1_r <= 1'b0;
            mosi2_r <= 1'b0;
            ss1_r   <= 1'b1;
            ss2_r   <= 1'b1;
        end else begin
            sck1_r  <= sck_i;
            sck2_r  <= sck1_r;
            sck3_r  <= sck2_r;
            mosi1_r <= mosi_i;
            mosi2_r <= mosi1_r;
            ss1_r   <= ss_n_i;
            ss2_r   <= ss1_r;
        end
    end

    // ==========================================================
    // Shift engine, shared by both roles
    assign slv_sel = en && !master_role_select && !ss2_r;
    assign s_ev    = slv_sel && (sck2_r ^ sck3_r);
    assign m_ev    = busy_r && (div_r == half_cycles({dbl_r, ctrl_r[1:0]}) - 7'h01);
    assign ev      = master_role_select ? m_ev : s_ev;
    assign din     = master_role_select ? miso_i : mosi2_r;
    assign samp    = (edge_r[0] == clock_sample_phase);
    assign fin     = ev && edge_r == sps_pkg::LAST_EDGE;
    assign out_bit = lsbf ? sh_r[0] : sh_r[7];
    assign in_prog = master_role_select ? busy_r : (slv_sel && edge_r != 4'h0);
    assign start   = data_wr && !in_prog && en && master_role_select;
    assign fin_byte = clock_sample_phase ? shift_in(sh_r, din, lsbf) : shift_in(sh_r, in_r, lsbf);

    // Master divider and busy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0;
            div_r  <= 7'h00;
        end else if (demote || !en || !master_role_select) begin
            busy_r <= 1'b0;
            div_r  <= 7'h00;
        end else if (start) begin
            busy_r <= 1'b1;
            div_r  <= 7'h00;
        end else if (busy_r) begin
            div_r  <= m_ev ? 7'h00 : div_r + 7'h01;
            if (fin)
                busy_r <= 1'b0;
        end
    end

    // Edge counter, transmit shifter, sampled bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_r <= 4'h0;
            sh_r   <= 8'h00;
            in_r   <= 1'b0;
        end else if (!en || demote || (!master_role_select && ss2_r)) begin
            edge_r <= 4'h0;
            in_r   <= 1'b0;
            if (data_wr)
                sh_r <= hwdata[7:0];
        end else if (data_wr && !in_prog) begin
            edge_r <= 4'h0;
            sh_r   <= hwdata[7:0];
        end else if (ev) begin
            edge_r <= edge_r + 4'h1;
            if (samp)
                in_r <= din;
            else if (!(clock_sample_phase && edge_r == 4'h0))
                sh_r <= shift_in(sh_r, in_r, lsbf); // Never on a sample edge, so mosi holds
        end
    end

    // Receive buffer loads only when a byte completes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxbuf_r <= 8'h00;
        end else if (fin) begin
            rxbuf_r <= fin_byte;
        end
    end

    // Master SCK level; returns to idle after 16 toggles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_r <= 1'b0;
        end else if (!busy_r) begin
            sck_r <= ctrl_r[sps_pkg::C_CLOCK_IDLE_POLARITY];
        end else if (m_ev) begin
            sck_r <= !sck_r;
        end
    end

    // ==========================================================
    // Pin drivers; every enable is a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_o   <= 1'b0;
            sck_oe  <= 1'b0;
            mosi_o  <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o  <= 1'b0;
            miso_oe <= 1'b0;
            ss_n_o  <= 1'b1;
            ss_n_oe <= 1'b0;
        end else begin
            sck_o   <= busy_r ? sck_r : ctrl_r[sps_pkg::C_CLOCK_IDLE_POLARITY];
            sck_oe  <= en && master_role_select && !demote;
            mosi_o  <= out_bit;
            mosi_oe <= en && master_role_select && !demote;
            miso_o  <= out_bit;
            miso_oe <= slv_sel && cfg_r[sps_pkg::G_MISO_OUT];
            // Select pin is an output only while G_SS_OUT is set and the port is not an enabled slave
            ss_n_o  <= cfg_r[sps_pkg::G_SS_VAL];
            ss_n_oe <= cfg_r[sps_pkg::G_SS_OUT] && !(en && !master_role_select);
        end
    end

    // ==========================================================
    // Checks
    a_write_collision_flag_on_busy: assert property (@(posedge hclk) disable iff (!hresetn)
        (data_wr && in_prog) |=> write_collision_flag_r)
        else $error("collision flag not set");

    a_ss_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        (!master_role_select && ss2_r) |=> edge_r == 4'h0)
        else $error("slave logic not reset on deselect");

    a_demote_role: assert property (@(posedge hclk) disable iff (!hresetn)
        demote |=> !master_role_select && done_r && !sck_oe)
        else $error("demotion incomplete");

    a_passive_miso: assert property (@(posedge hclk) disable iff (!hresetn)
        (!master_role_select && ss2_r) |=> !miso_oe)
        else $error("passive slave drives miso");

    a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_req == $past(done_r && ctrl_r[sps_pkg::C_IE] && cfg_r[sps_pkg::G_GIE]))
        else $error("interrupt request mismatch");

    a_done_fin: assert property (@(posedge hclk) disable iff (!hresetn)
        fin |=> done_r && rxbuf_r == $past(fin_byte))
        else $error("byte completion not flagged");

    a_fast_byte: assert property (@(posedge hclk) disable iff (!hresetn)
        (start && !demote && dbl_r && ctrl_r[1:0] == 2'h0) |=> edge_r == 4'h0 ##15 fin ##1 !busy_r)
        else $error("double rate byte not 16 cycles");

    a_idle_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        !busy_r |=> sck_o == $past(ctrl_r[sps_pkg::C_CLOCK_IDLE_POLARITY]))
        else $error("clock not at idle level");

    a_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
        !en |=> !sck_oe && !mosi_oe && !miso_oe && !busy_r)
        else $error("disabled port active");

    a_slow_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        (busy_r && m_ev && !dbl_r && ctrl_r[1:0] == 2'h0 && !fin) |=> !m_ev ##1 m_ev)
        else $error("divide by four half period wrong");
endmodule

// File: tb/sps_peer.sv
// Far-end serial device: a slave answering the port's master, plus a slow master.
// Assumes the bench resolves every pin from all drivers and feeds levels back.
module sps_peer (
    input  wire logic       hclk,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       miso,
    input  wire logic       ss_n,
    input  wire logic [1:0] mode,
    input  wire logic       lsbf,
    input  wire logic [7:0] tx,
    output logic            p_sck,
    output logic            p_mosi,
    output logic            p_miso,
    output logic            p_ss_n,
    output logic [7:0]      rx
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Slave side
    logic       tog = 1'b0;
    logic       mact = 1'b0;
    logic       m_mosi = 1'b0;
    logic [3:0] nset = 4'h0;
    logic [2:0] idx;
    initial begin
        p_sck = 1'b0;
        p_ss_n = 1'b1;
    end
    assign idx = 3'(mode[0] ? nset - 4'h1 : nset);
    // Released lines toggle so nobody can read a stale bit
    assign p_miso = (!ss_n && !mact) ? tx[lsbf ? idx : 3'h7 - idx] : tog;
    assign p_mosi = mact ? m_mosi : tog;
    always @(posedge hclk) begin
        tog <= !tog;
    end
    // Act on the pin edges themselves; a late miso would be read stale
    always @(posedge sck or negedge sck or posedge ss_n) begin
        if (ss_n || mact) begin
            nset <= 4'h0;
        end else if ((sck != mode[1]) ^ mode[0]) begin
            rx <= lsbf ? {mosi, rx[7:1]} : {rx[6:0], mosi};
        end else begin
            nset <= nset + 4'h1;
        end
    end
    // ==========================================================
    // Master side: mode 0, MSB first, six clocks a half period
    task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] got);
        mact <= 1'b1;
        p_ss_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            m_mosi <= b[7 - i];
            repeat (6) @(posedge hclk);
            p_sck <= 1'b1;
            got = {got[6:0], miso};
            repeat (6) @(posedge hclk);
            p_sck <= 1'b0;
        end
        repeat (6) @(posedge hclk);
        p_ss_n <= 1'b1;
        mact <= 1'b0;
        @(posedge hclk);
    endtask
endmodule

// File: tb/spi_master_slave_port_test.sv
// Self-checking bench of the serial port through its register bus.
// Assumes sps_pkg, sps_port and sps_peer are compiled before it.
module spi_master_slave_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        vector_taken = 1'b0;
    logic        hreadyout, hresp, irq_req;
    logic [31:0] hrdata, r;
    logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
    logic        p_sck, p_mosi, p_miso, p_ss_n, sck_q;
    logic [1:0]  mode = 2'h0;
    logic        lsbf = 1'b0;
    logic [7:0]  tx = 8'h00;
    logic [7:0]  rx, got;
    int          mismatches = 0;
    int          checks_done = 0;
    int          togs = 0;
    int          gap = 0;
    int          run = 0;
    int          n0;
    int          half[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
    // Pin levels from whoever drives them
    wire sck = sck_oe ? sck_o : p_sck;
    wire mosi = mosi_oe ? mosi_o : p_mosi;
    wire miso = miso_oe ? miso_o : p_miso;
    wire ss_n = ss_n_oe ? ss_n_o : p_ss_n;
    always #5 hclk = !hclk;
    sps_port DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .vector_taken, .irq_req,
        .sck_i(sck), .sck_o, .sck_oe, .mosi_i(mosi), .mosi_o, .mosi_oe,
        .miso_i(miso), .miso_o, .miso_oe, .ss_n_i(ss_n), .ss_n_o, .ss_n_oe);
    sps_peer peer (.hclk, .sck, .mosi, .miso, .ss_n, .mode, .lsbf, .tx,
        .p_sck, .p_mosi, .p_miso, .p_ss_n, .rx);
    // Serial clock toggle count and spacing of the latest toggle
    always @(posedge hclk) begin
        sck_q <= sck_o;
        run <= (sck_o != sck_q) ? 1 : run + 1;
        if (sck_o != sck_q) begin
            togs <= togs + 1;
            gap <= run;
        end
    end
    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got_v);
        checks_done++;
        if (got_v !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got_v);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= sps_pkg::TR_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(what, exp, r);
    endtask
    // Poll flags; a read that sees done also arms its clearing
    task automatic wait_done();
        do bus(1'b0, sps_pkg::OFF_FLAGS, 8'h00); while (r[sps_pkg::F_DONE] !== 1'b1);
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Runs are a few thousand cycles; this only cuts a hang short
    initial begin
        repeat (50000) @(posedge hclk);
        mismatches++;
        give_verdict();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("ctrl", sps_pkg::OFF_CTRL, 32'h0);
        rdc("flags", sps_pkg::OFF_FLAGS, 32'h0);
        rdc("cfg", sps_pkg::OFF_CFG, 32'h4);
        rdc("unmapped", 8'h10, 32'h0);
        chk("hresp", 32'h0, hresp);
        bus(1'b1, sps_pkg::OFF_CTRL, 8'h10);
        bus(1'b1, sps_pkg::OFF_DATA, 8'h55);
        repeat (40) @(posedge hclk);
        chk("sck drive off", 32'h0, sck_oe);
        rdc("flags off", sps_pkg::OFF_FLAGS, 32'h0);
        // Every mode and bit order, master at the fastest normal rate
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, sps_pkg::OFF_CFG, 8'h6);
            repeat (2) @(posedge hclk);
            chk("select high", 32'h1, ss_n);
            mode <= i[1:0];
            lsbf <= i[2];
            tx <= 8'h3C + 8'(i);
            bus(1'b1, sps_pkg::OFF_CTRL, {2'b01, i[2], 1'b1, i[1:0], 2'b00});
            bus(1'b1, sps_pkg::OFF_CFG, 8'h2);
            repeat (2) @(posedge hclk);
            chk("select low", 32'h0, ss_n);
            chk("idle sck", 32'(i[1]), sck_o);
            bus(1'b1, sps_pkg::OFF_DATA, 8'hA0 + 8'(i));
            wait_done();
            chk("peer byte", 32'hA0 + 32'(i), rx);
            rdc("rx byte", sps_pkg::OFF_DATA, 32'h3C + 32'(i));
            rdc("done cleared", sps_pkg::OFF_FLAGS, 32'h0);
        end
        mode <= 2'h0;
        lsbf <= 1'b0;
        // Every divider code, double bit included
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, sps_pkg::OFF_FLAGS, {7'h0, c[2]});
            bus(1'b1, sps_pkg::OFF_CTRL, {6'h14, c[1:0]});
            // A polarity change settles before counting starts
            repeat (3) @(posedge hclk);
            n0 = togs;
            bus(1'b1, sps_pkg::OFF_DATA, 8'hC3);
            wait_done();
            repeat (2) @(posedge hclk);
            chk("toggles", 32'd16, 32'(togs - n0));
            chk("half period", 32'(half[c]), 32'(gap));
            bus(1'b0, sps_pkg::OFF_DATA, 8'h00);
        end
        // Data write during a transfer
        bus(1'b1, sps_pkg::OFF_FLAGS, 8'h00);
        bus(1'b1, sps_pkg::OFF_CFG, 8'h6);
        bus(1'b1, sps_pkg::OFF_CTRL, 8'h53);
        bus(1'b1, sps_pkg::OFF_CFG, 8'h2);
        bus(1'b1, sps_pkg::OFF_DATA, 8'h81);
        bus(1'b1, sps_pkg::OFF_DATA, 8'h7E);
        wait_done();
        chk("collision", 32'h1, r[sps_pkg::F_WRITE_COLLISION_FLAG]);
        chk("first byte kept", 32'h81, rx);
        bus(1'b0, sps_pkg::OFF_DATA, 8'h00);
        rdc("both cleared", sps_pkg::OFF_FLAGS, 32'h0);
        // Another master selects us while master
        // Select pin driven high first, so the switch to input shows no low
        bus(1'b1, sps_pkg::OFF_CFG, 8'h6);
        repeat (4) @(posedge hclk);
        bus(1'b1, sps_pkg::OFF_CFG, 8'h8);
        bus(1'b1, sps_pkg::OFF_CTRL, 8'hD0);
        rdc("still master", sps_pkg::OFF_CTRL, 32'hD0);
        peer.p_ss_n <= 1'b0;
        repeat (8) @(posedge hclk);
        chk("irq", 32'h1, irq_req);
        chk("sck released", 32'h0, sck_oe);
        chk("mosi released", 32'h0, mosi_oe);
        chk("miso not enabled", 32'h0, miso_oe);
        rdc("demoted", sps_pkg::OFF_CTRL, 32'hC0);
        rdc("done set", sps_pkg::OFF_FLAGS, 32'h80);
        vector_taken <= 1'b1;
        @(posedge hclk);
        vector_taken <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("irq low", 32'h0, irq_req);
        rdc("vector clear", sps_pkg::OFF_FLAGS, 32'h0);
        peer.p_ss_n <= 1'b1;
        // Slave role with an outside master
        bus(1'b1, sps_pkg::OFF_CFG, 8'h1);
        bus(1'b1, sps_pkg::OFF_CTRL, 8'h43);
        bus(1'b1, sps_pkg::OFF_DATA, 8'h96);
        chk("miso idle", 32'h0, miso_oe);
        peer.p_ss_n <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("miso driven", 32'h1, miso_oe);
        peer.p_ss_n <= 1'b1;
        repeat (6) @(posedge hclk);
        peer.xfer(8'h5A, 8, got);
        chk("slave sent", 32'h96, got);
        rdc("slave done", sps_pkg::OFF_FLAGS, 32'h80);
        rdc("slave byte", sps_pkg::OFF_DATA, 32'h5A);
        chk("miso off", 32'h0, miso_oe);
        peer.xfer(8'hF0, 4, got);
        rdc("partial dropped", sps_pkg::OFF_FLAGS, 32'h0);
        peer.xfer(8'h3C, 8, got);
        rdc("realigned byte", sps_pkg::OFF_DATA, 32'h3C);
        give_verdict();
    end
endmodule
